// file: core/bfs_cfg.svh
// constants of the burst flash read port and its controller
`ifndef BFS_CFG_SVH
`define BFS_CFG_SVH

`define BFS_CLK_MHZ          10
`define BFS_CLK_PERIOD_NS    100
`define BFS_ADDR_W           24
`define BFS_DATA_W           16
`define BFS_WS_W             4
`define BFS_PIN_W            29
// lowest burst clock per burst kind, in kHz
`define BFS_MIN_KHZ_8        60
`define BFS_MIN_KHZ_16       120
`define BFS_MIN_KHZ_32       250
`define BFS_MIN_KHZ_CONT     1000
// wait-state table: frequency limits and the least count per limit
`define BFS_F0 27
`define BFS_F1 40
`define BFS_F2 54
`define BFS_F3 66
`define BFS_F4 80
`define BFS_F5 95
`define BFS_F6 104
`define BFS_WRAP_WS   {4'd3, 4'd4, 4'd5, 4'd6, 4'd7, 4'd8, 4'd11}
`define BFS_CONT_WS   {4'd3, 4'd4, 4'd6, 4'd7, 4'd8, 4'd9, 4'd11}
`define BFS_WS_RESET  4'h7
`define BFS_GROUP_BITS 3
// reset timing
`define BFS_RST_PULSE_US     30
`define BFS_RST_PULSE_CYC    ((`BFS_RST_PULSE_US * 1000) / `BFS_CLK_PERIOD_NS)
`define BFS_RST_SEL_NS       200
`define BFS_RST_SEL_CYC      ((`BFS_RST_SEL_NS + `BFS_CLK_PERIOD_NS - 1) / `BFS_CLK_PERIOD_NS)
// controller transfer shape
`define BFS_CHUNK_WORDS      2
`define BFS_DRAIN_CYC        6
// controller register map
`define BFS_REG_CTRL         8'h00
`define BFS_REG_CFG          8'h04
`define BFS_REG_ADDR         8'h08
`define BFS_REG_LEN          8'h0C
`define BFS_REG_STATUS       8'h10
`define BFS_REG_DATA         8'h14
`define BFS_CTRL_START       0
`define BFS_CTRL_CFG         1
`define BFS_CTRL_HWRST       2
`define BFS_CFG_WRAP         4
`define BFS_ST_BUSY          0
`define BFS_ST_CONFIGURED    1
`define BFS_ST_VALID         2
`define BFS_ST_LEVEL         3
`define BFS_ST_CLK_OK        5

`endif

// file: core/bfs_pkg.sv
// types and shared decoding of the burst flash read port
`include "bfs_cfg.svh"
package bfs_pkg;

   typedef enum logic [1:0] {FL_IDLE, FL_WAIT, FL_STREAM} bfs_fl_e;

   typedef enum logic [2:0] {CT_RST_HOLD, CT_RST_WAIT, CT_IDLE, CT_CFG, CT_ADDR,
                             CT_DATA, CT_GAP} bfs_ct_e;

   typedef struct packed {
      logic [1:0][`BFS_PIN_W-1:0]  sync;
      bfs_fl_e                     st;
      logic [`BFS_WS_W-1:0]        ws;
      logic                        wrap;
      logic [`BFS_WS_W-1:0]        lat;
      logic [`BFS_ADDR_W-1:0]      addr;
      logic                        rdy_o;
      logic                        rdy_oe;
      logic [`BFS_DATA_W-1:0]      dq_o;
      logic                        dq_oe;
   } bfs_fl_s;

   typedef struct packed {
      bfs_ct_e                     st;
      logic [8:0]                  cnt;
      logic                        rst_n;
      logic                        cs_n;
      logic                        oe_n;
      logic                        avd_n;
      logic                        cfg_n;
      logic [`BFS_ADDR_W-1:0]      pin_addr;
      logic [`BFS_WS_W-1:0]        ws;
      logic                        wrap;
      logic                        configured;
      logic [`BFS_ADDR_W-1:0]      base;
      logic [15:0]                 done;
      logic [15:0]                 remain;
      logic [1:0]                  chunk;
      logic [1:0]                  got;
      logic [1:0][`BFS_DATA_W:0]   sync;
      logic [1:0][`BFS_DATA_W-1:0] buf_mem;
      logic                        wp;
      logic                        rp;
      logic [1:0]                  level;
      logic [31:0]                 rd_data;
   } bfs_ct_s;

   // least wait-state count for a clock rate and burst kind
   function automatic logic [`BFS_WS_W-1:0] min_wait(input int mhz, input logic wrap);
      logic [27:0] tbl;
      int          idx;
      tbl = wrap ? `BFS_WRAP_WS : `BFS_CONT_WS;
      if (mhz <= `BFS_F0) idx = 6;
      else if (mhz <= `BFS_F1) idx = 5;
      else if (mhz <= `BFS_F2) idx = 4;
      else if (mhz <= `BFS_F3) idx = 3;
      else if (mhz <= `BFS_F4) idx = 2;
      else if (mhz <= `BFS_F5) idx = 1;
      else idx = 0;
      return tbl[idx*4 +: 4];
   endfunction

   // count raised to the least legal value
   function automatic logic [`BFS_WS_W-1:0] legal_wait(input logic [`BFS_WS_W-1:0] ws,
                                                       input logic wrap);
      logic [`BFS_WS_W-1:0] lo;
      lo = min_wait(`BFS_CLK_MHZ, wrap);
      return (ws < lo) ? lo : ws;
   endfunction

   // word address k words on within a burst
   function automatic logic [`BFS_ADDR_W-1:0] step_addr(input logic [`BFS_ADDR_W-1:0] a,
                                                        input logic [15:0] k,
                                                        input logic wrap);
      logic [`BFS_ADDR_W-1:0] lin;
      lin = a + {8'h00, k};
      return wrap ? {a[`BFS_ADDR_W-1:`BFS_GROUP_BITS], lin[`BFS_GROUP_BITS-1:0]} : lin;
   endfunction

endpackage

// file: core/bfs_if.sv
// pins between the burst flash and its memory controller
`timescale 1ns/1ps
`include "bfs_cfg.svh"
interface bfs_if;
   logic                   rst_n;
   logic                   chip_sel_n;
   logic                   out_en_n;
   logic                   address_valid_strobe_n;
   logic                   cfg_wr_n;
   logic [`BFS_ADDR_W-1:0] addr;
   logic                   rdy_o;
   logic                   rdy_oe;
   logic [`BFS_DATA_W-1:0] dq_o;
   logic                   dq_oe;
   logic                   rdy;
   logic [`BFS_DATA_W-1:0] dq;

   // undriven lines read as low, as with a weak pull-down on the board
   assign rdy = rdy_oe ? rdy_o : 1'b0;
   assign dq  = dq_oe ? dq_o : '0;

   modport ctrl (output rst_n, chip_sel_n, out_en_n, address_valid_strobe_n, cfg_wr_n,
                 addr, input rdy, dq);
   modport flash (input rst_n, chip_sel_n, out_en_n, address_valid_strobe_n, cfg_wr_n,
                  addr, output rdy_o, rdy_oe, dq_o, dq_oe);
endinterface

// file: core/bfs_flash.sv
// flash end: synchronous burst read port of the memory
`timescale 1ns/1ps
`include "bfs_cfg.svh"
module bfs_flash (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   srst,
   // pins toward the controller
   bfs_if.flash                        pins,
   // array read port
   output logic [`BFS_ADDR_W-1:0]      core_addr,
   input  wire logic [`BFS_DATA_W-1:0] core_data
);
   bfs_pkg::bfs_fl_s r;
   bfs_pkg::bfs_fl_s n;

   logic                   s_rst_n;
   logic                   s_cs_n;
   logic                   s_oe_n;
   logic                   s_avd_n;
   logic                   s_cfg_n;
   logic [`BFS_ADDR_W-1:0] s_addr;

   assign {s_rst_n, s_cs_n, s_oe_n, s_avd_n, s_cfg_n, s_addr} = r.sync[1];

   always_comb
   begin
      n = r;
      n.sync[0] = {pins.rst_n, pins.chip_sel_n, pins.out_en_n,
                   pins.address_valid_strobe_n, pins.cfg_wr_n, pins.addr};
      n.sync[1] = r.sync[0];
      n.rdy_oe = ~s_cs_n;
      n.dq_oe  = ~s_oe_n;
      case (r.st)
         bfs_pkg::FL_IDLE:
         begin
            n.rdy_o = 1'b0;
         end
         bfs_pkg::FL_WAIT:
         begin
            // word appears at the edge wait-1 periods after the address edge
            if (r.lat == 4'h1)
            begin
               n.dq_o  = core_data;
               n.rdy_o = 1'b1;
               n.addr  = bfs_pkg::step_addr(r.addr, 16'h0001, r.wrap);
               n.st    = bfs_pkg::FL_STREAM;
            end
            else
               n.lat = r.lat - 4'h1;
         end
         bfs_pkg::FL_STREAM:
         begin
            n.dq_o  = core_data;
            n.rdy_o = 1'b1;
            n.addr  = bfs_pkg::step_addr(r.addr, 16'h0001, r.wrap);
         end
         default:
            n.st = bfs_pkg::FL_IDLE;
      endcase
      if (!s_cs_n && !s_avd_n)
      begin
         if (!s_cfg_n)
         begin
            n.wrap = s_addr[`BFS_CFG_WRAP];
            n.ws   = bfs_pkg::legal_wait(s_addr[`BFS_WS_W-1:0], s_addr[`BFS_CFG_WRAP]);
            n.st   = bfs_pkg::FL_IDLE;
         end
         else
         begin
            n.addr  = s_addr;
            n.lat   = r.ws - 4'h1;
            n.rdy_o = 1'b0;
            n.st    = bfs_pkg::FL_WAIT;
         end
      end
      if (s_cs_n)
      begin
         n.st    = bfs_pkg::FL_IDLE;
         n.rdy_o = 1'b0;
      end
      if (!s_rst_n)
      begin
         n.st    = bfs_pkg::FL_IDLE;
         n.ws    = `BFS_WS_RESET;
         n.wrap  = 1'b1;
         n.rdy_o = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         r         <= '0;
         r.sync    <= {2{{5{1'b1}}, {`BFS_ADDR_W{1'b0}}}};
         r.ws      <= `BFS_WS_RESET;
         r.wrap    <= 1'b1;
      end
      else
         r <= n;
   end

   assign pins.rdy_o  = r.rdy_o;
   assign pins.rdy_oe = r.rdy_oe;
   assign pins.dq_o   = r.dq_o;
   assign pins.dq_oe  = r.dq_oe;
   assign core_addr   = r.addr;
endmodule

// file: core/bfs_ctrl.sv
// controller end: memory controller issuing synchronous burst reads
// Contract
// - flash latches address on rising clock edge
// - wrapping mode wait count meets frequency minimum
// - continuous mode wait count meets frequency minimum
// - first word after wait minus one periods
// - ready floats on deselect, data on disable
// - burst clock stays above the minimum rate
// - wait 200 ns from reset release to select
// - hold reset at power-up, reset again later
`timescale 1ns/1ps
`include "bfs_cfg.svh"
module bfs_ctrl (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   // pins toward the flash
   bfs_if.ctrl              pins
);
   bfs_pkg::bfs_ct_s r;
   bfs_pkg::bfs_ct_s n;

   logic                   in_rdy;
   logic [`BFS_DATA_W-1:0] in_dq;
   logic                   push;
   logic                   pop;
   logic                   clk_ok;
   logic                   wr_ctrl;
   logic                   wr_cfg;
   logic [15:0]            take;

   assign {in_rdy, in_dq} = r.sync[1];
   // 10 MHz is far above every burst kind's lower limit
   assign clk_ok  = (`BFS_CLK_MHZ * 1000) >= `BFS_MIN_KHZ_CONT;
   assign wr_ctrl = reg_wr && (reg_addr == `BFS_REG_CTRL);
   assign wr_cfg  = reg_wr && (reg_addr == `BFS_REG_CFG);
   // chunks are only two words so a full buffer never meets an unstoppable burst
   assign take    = (r.remain < 16'(`BFS_CHUNK_WORDS)) ? r.remain : 16'(`BFS_CHUNK_WORDS);
   assign push    = (r.st == bfs_pkg::CT_DATA) && in_rdy && (r.got < r.chunk);
   assign pop     = reg_rd && (reg_addr == `BFS_REG_DATA) && (r.level != 2'd0);

   always_comb
   begin
      n = r;
      n.sync[0] = {pins.rdy, pins.dq};
      n.sync[1] = r.sync[0];
      n.rd_data = 32'h0000_0000;
      // register writes
      if (wr_cfg)
      begin
         n.wrap = reg_wdata[`BFS_CFG_WRAP];
         n.ws   = bfs_pkg::legal_wait(reg_wdata[`BFS_WS_W-1:0], reg_wdata[`BFS_CFG_WRAP]);
      end
      if (reg_wr && (reg_addr == `BFS_REG_ADDR))
         n.base = reg_wdata[`BFS_ADDR_W-1:0];
      if (reg_wr && (reg_addr == `BFS_REG_LEN) && (r.remain == 16'h0000))
      begin
         n.remain = reg_wdata[15:0];
         n.done   = 16'h0000;
      end
      // register reads, answered one cycle later
      if (reg_rd)
      begin
         case (reg_addr)
            `BFS_REG_CFG:    n.rd_data = {27'h000_0000, r.wrap, r.ws};
            `BFS_REG_ADDR:   n.rd_data = {8'h00, r.base};
            `BFS_REG_LEN:    n.rd_data = {16'h0000, r.remain};
            `BFS_REG_STATUS:
               n.rd_data = {26'h000_0000, clk_ok, r.level, (r.level != 2'd0), r.configured,
                            (r.st != bfs_pkg::CT_IDLE) || (r.remain != 16'h0000)};
            `BFS_REG_DATA:   n.rd_data = {16'h0000, r.buf_mem[r.rp]};
            default:         n.rd_data = 32'h0000_0000;
         endcase
      end
      // two-entry buffer
      if (push)
      begin
         n.buf_mem[r.wp] = in_dq;
         n.wp            = ~r.wp;
         n.got           = r.got + 2'd1;
      end
      if (pop)
         n.rp = ~r.rp;
      n.level = r.level + {1'b0, push} - {1'b0, pop};
      // sequencer
      case (r.st)
         bfs_pkg::CT_RST_HOLD:
         begin
            n.rst_n = 1'b0;
            n.cs_n  = 1'b1;
            if (r.cnt == 9'(`BFS_RST_PULSE_CYC - 1))
            begin
               n.cnt   = 9'h000;
               n.rst_n = 1'b1;
               n.st    = bfs_pkg::CT_RST_WAIT;
            end
            else
               n.cnt = r.cnt + 9'h001;
         end
         bfs_pkg::CT_RST_WAIT:
         begin
            if (r.cnt == 9'(`BFS_RST_SEL_CYC - 1))
               n.st = bfs_pkg::CT_IDLE;
            else
               n.cnt = r.cnt + 9'h001;
         end
         bfs_pkg::CT_IDLE:
         begin
            if (wr_ctrl && reg_wdata[`BFS_CTRL_CFG])
               n.st = bfs_pkg::CT_CFG;
            else if (r.configured && (r.remain != 16'h0000) && (r.level == 2'd0))
            begin
               n.pin_addr = bfs_pkg::step_addr(r.base, r.done, r.wrap);
               n.chunk    = take[1:0];
               n.got      = 2'd0;
               n.cs_n     = 1'b0;
               n.oe_n     = 1'b0;
               n.avd_n    = 1'b0;
               n.st       = bfs_pkg::CT_ADDR;
            end
         end
         bfs_pkg::CT_CFG:
         begin
            // one select cycle carrying the settings on the address lines
            n.pin_addr   = {19'h0_0000, r.wrap, r.ws};
            n.cs_n       = 1'b0;
            n.avd_n      = 1'b0;
            n.cfg_n      = 1'b0;
            n.configured = 1'b1;
            n.cnt        = 9'h000;
            n.st         = bfs_pkg::CT_GAP;
         end
         bfs_pkg::CT_ADDR:
         begin
            n.avd_n = 1'b1;
            n.st    = bfs_pkg::CT_DATA;
         end
         bfs_pkg::CT_DATA:
         begin
            if (push && (r.got + 2'd1 == r.chunk))
            begin
               n.cs_n   = 1'b1;
               n.oe_n   = 1'b1;
               n.done   = r.done + {14'h0000, r.chunk};
               n.remain = r.remain - {14'h0000, r.chunk};
               n.cnt    = 9'h000;
               n.st     = bfs_pkg::CT_GAP;
            end
         end
         bfs_pkg::CT_GAP:
         begin
            n.cs_n  = 1'b1;
            n.avd_n = 1'b1;
            n.cfg_n = 1'b1;
            if (r.cnt == 9'(`BFS_DRAIN_CYC - 1))
               n.st = bfs_pkg::CT_IDLE;
            else
               n.cnt = r.cnt + 9'h001;
         end
         default:
            n.st = bfs_pkg::CT_IDLE;
      endcase
      // later hardware reset on request, aborting any transfer
      if (wr_ctrl && reg_wdata[`BFS_CTRL_HWRST])
      begin
         n.st         = bfs_pkg::CT_RST_HOLD;
         n.cnt        = 9'h000;
         n.rst_n      = 1'b0;
         n.cs_n       = 1'b1;
         n.oe_n       = 1'b1;
         n.avd_n      = 1'b1;
         n.cfg_n      = 1'b1;
         n.configured = 1'b0;
         n.remain     = 16'h0000;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         r       <= '0;
         r.st    <= bfs_pkg::CT_RST_HOLD;
         r.cs_n  <= 1'b1;
         r.oe_n  <= 1'b1;
         r.avd_n <= 1'b1;
         r.cfg_n <= 1'b1;
         r.ws    <= `BFS_WS_RESET;
         r.wrap  <= 1'b1;
      end
      else
         r <= n;
   end

   assign reg_rdata                   = r.rd_data;
   assign pins.rst_n                  = r.rst_n;
   assign pins.chip_sel_n             = r.cs_n;
   assign pins.out_en_n               = r.oe_n;
   assign pins.address_valid_strobe_n = r.avd_n;
   assign pins.cfg_wr_n               = r.cfg_n;
   assign pins.addr                   = r.pin_addr;
endmodule

// file: bench/bfs_asserts.sv
// concurrent checks on the pins between the flash and its controller
`timescale 1ns/1ps
`include "bfs_cfg.svh"
module bfs_asserts (
   // clock and reset
   input wire logic                   clk,
   input wire logic                   srst,
   // controller side
   input wire logic                   rst_n,
   input wire logic                   chip_sel_n,
   input wire logic                   out_en_n,
   input wire logic                   address_valid_strobe_n,
   input wire logic                   cfg_wr_n,
   input wire logic [`BFS_ADDR_W-1:0] addr,
   // flash side
   input wire logic                   rdy_o,
   input wire logic                   rdy_oe,
   input wire logic [`BFS_DATA_W-1:0] dq_o,
   input wire logic                   dq_oe
);
   logic [9:0] low_cnt_r;

   // cleared by srst so an unknown pin level at start never reaches the count
   always_ff @(posedge clk)
   begin
      if (srst || rst_n)
         low_cnt_r <= 10'h000;
      else
         low_cnt_r <= low_cnt_r + 10'h001;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_rdy_float_desel: assert property (chip_sel_n [*3] |=> !rdy_oe)
      else $error("ready driven while deselected");
   a_dq_float_off: assert property (out_en_n [*3] |=> !dq_oe)
      else $error("data driven while output disabled");
   a_ready_with_data: assert property ((rdy_oe && rdy_o) |-> dq_oe)
      else $error("ready without data driven");
   a_first_word_bound: assert property (
      ($fell(address_valid_strobe_n) && cfg_wr_n) |-> ##[3:24] (rdy_oe && rdy_o))
      else $error("first burst word late");
   a_burst_next_word: assert property ($rose(rdy_oe && rdy_o) |=> (rdy_oe && rdy_o))
      else $error("second burst word missing");
   a_addr_held_capture: assert property (
      $fell(address_valid_strobe_n) |=> ($stable(addr) && address_valid_strobe_n))
      else $error("address moved after strobe");
   a_strobe_when_sel: assert property (!address_valid_strobe_n |-> !chip_sel_n)
      else $error("address strobe without select");
   a_cfg_wait_min: assert property (
      (!address_valid_strobe_n && !cfg_wr_n) |-> (addr[3:0] >= 4'h3))
      else $error("wait count below minimum");
   a_select_after_rst: assert property ($rose(rst_n) |-> chip_sel_n [*2])
      else $error("select too soon after reset");
   a_reset_pulse_len: assert property ($rose(rst_n) |-> (low_cnt_r >= `BFS_RST_PULSE_CYC))
      else $error("reset pulse too short");
endmodule

// file: bench/testbench.sv
// self-checking bench: controller and flash joined by their pin interface
`timescale 1ns/1ps
`include "bfs_cfg.svh"
module testbench;
   logic        clk;
   logic        srst;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic [23:0] core_addr;
   logic [15:0] core_data;
   int          error_cnt;
   int          comparisons;

   bfs_if pins_if ();

   bfs_ctrl bfs_ctrl_i (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins(pins_if.ctrl));
   bfs_flash bfs_flash_i (.clk(clk), .srst(srst), .pins(pins_if.flash),
      .core_addr(core_addr), .core_data(core_data));
   bfs_asserts bfs_asserts_i (.clk(clk), .srst(srst), .rst_n(pins_if.rst_n),
      .chip_sel_n(pins_if.chip_sel_n), .out_en_n(pins_if.out_en_n),
      .address_valid_strobe_n(pins_if.address_valid_strobe_n), .cfg_wr_n(pins_if.cfg_wr_n),
      .addr(pins_if.addr), .rdy_o(pins_if.rdy_o), .rdy_oe(pins_if.rdy_oe),
      .dq_o(pins_if.dq_o), .dq_oe(pins_if.dq_oe));

   // byte swap and 5a5a mask give every address in a 16-bit span its own word
   function automatic logic [15:0] word_of(input logic [23:0] a);
      return {a[7:0], a[15:8]} ^ 16'h5a5a;
   endfunction

   function automatic logic [23:0] word_addr(input logic [23:0] a, input int k, input logic w);
      logic [23:0] lin;
      lin = a + 24'(k);
      return w ? {a[23:3], lin[2:0]} : lin;
   endfunction

   assign core_data = word_of(core_addr);

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
      @(posedge clk);
   endtask

   task automatic poll(input int b, input logic v);
      logic [31:0] s;
      int          n;
      n = 0;
      rd(`BFS_REG_STATUS, s);
      while (s[b] !== v && n < 500)
      begin
         rd(`BFS_REG_STATUS, s);
         n++;
      end
      check("status bit", {31'h0, s[b]}, {31'h0, v});
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic t_reset();
      logic [31:0] d;
      int          n;
      check("select idle", {31'h0, pins_if.chip_sel_n}, 32'h0000_0001);
      check("flash reset", {31'h0, pins_if.rst_n}, 32'h0000_0000);
      rd(8'hfc, d);
      check("unmapped read", d, 32'h0000_0000);
      n = 0;
      while (pins_if.rst_n !== 1'b1 && n < 400)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      // back onto the edge so the next strobe is set up at the clock
      @(posedge clk);
      wr(`BFS_REG_CTRL, 32'h0000_0004);
      // the strobe edge lowered it one edge before the write task returns
      check("reset asserted", {31'h0, pins_if.rst_n}, 32'h0000_0000);
      n = 1;
      while (pins_if.rst_n === 1'b0 && n < 400)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      @(posedge clk);
      check("reset pulse", 32'(n), 32'(`BFS_RST_PULSE_CYC));
      $display("test reset done");
   endtask

   // the long stall lets the buffer fill so the sequencer must hold off
   task automatic t_burst(input logic [31:0] cfg, input logic [23:0] base, input int len);
      logic [31:0] d;
      wr(`BFS_REG_CFG, cfg);
      wr(`BFS_REG_CTRL, 32'h0000_0002);
      poll(`BFS_ST_CONFIGURED, 1'b1);
      poll(`BFS_ST_BUSY, 1'b0);
      wr(`BFS_REG_ADDR, {8'h00, base});
      wr(`BFS_REG_LEN, 32'(len));
      wr(`BFS_REG_LEN, 32'h0000_0001);
      repeat (80) @(posedge clk);
      rd(`BFS_REG_STATUS, d);
      check("full level", {30'h0, d[4:3]}, 32'h0000_0002);
      check("clock rate ok", {31'h0, d[`BFS_ST_CLK_OK]}, 32'h0000_0001);
      for (int k = 0; k < len; k++)
      begin
         poll(`BFS_ST_VALID, 1'b1);
         rd(`BFS_REG_DATA, d);
         check("burst word", {16'h0, d[15:0]}, {16'h0, word_of(word_addr(base, k, cfg[4]))});
      end
      poll(`BFS_ST_BUSY, 1'b0);
      rd(`BFS_REG_STATUS, d);
      check("drained", {29'h0, d[4:2]}, 32'h0000_0000);
      $display("test burst cfg %h done", cfg);
   endtask

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      give_verdict();
   end

   initial
   begin
      srst        = 1'b1;
      reg_addr    = 8'h00;
      reg_wdata   = 32'h0000_0000;
      reg_wr      = 1'b0;
      reg_rd      = 1'b0;
      error_cnt   = 0;
      comparisons = 0;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_burst(32'h0000_0002, 24'h00_0006, 5);
      t_burst(32'h0000_0015, 24'h00_001d, 6);
      give_verdict();
   end
endmodule
